// ==== usb_endpoint_response_engine.sv ====
// Function
// - Only valid transactions are answered; invalid ones get no response at all.
// - Completed valid transactions other than a stalled IN in mode 1001, and corrupted OUT/SETUP buffers, raise an endpoint event.
// - Data is valid when count including CRC is at most size plus two, CRC good.
// - OUT endpoints ignore IN tokens, except mode 1001 stalls them when stall-select is set; IN endpoints ignore OUT tokens.
// - IN/OUT flags update at transaction end; SETUP flag at data phase start.
// - Endpoint 0 mode and count lock after an ACK; a CPU read of an endpoint 0 register unlocks them.
// - Valid SETUP: store, update count, set flags, mode 0001, ACK, event.
// - Mode 0001 NAKs IN and OUT, mode 1110 NAKs IN; flag and event.
// - Mode 0011 stalls IN and OUT, sets flag, raises event, mode kept.
// - Mode 1011 valid OUT: store, flags, ACK, mode 1010, event.
// - Modes 1011, 1010, 0110 answer IN with zero-length data; in, ack, event.
// - Modes 1010, 1000 NAK valid OUT with event; invalid OUT ignored silently.
// - Mode 0110 stalls valid OUT, sets out flag, mode 0011, event.
// - Modes 1111, 1110, 0010: two-byte OUT, toggle 1 ACKs, toggle 0 stalls.
// - Same modes: other-length valid OUT updates count, stalls, mode 0011, event.
// - Mode 1111 IN sends data; on host ACK set flags, mode 1110, event.
// - Mode 0010 stalls IN, sets in flag, mode 0011, event.
// - Mode 1001 valid OUT stored, ACK, mode 1000, event; IN ignored or stalled.
// - Mode 1101 IN sends data or stall; in, ack, mode 1100, event.
// - All endpoints reset to disabled mode 0000 until firmware writes another.
// - Stall-select is bit 7 of each non-control endpoint mode register.
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_response_engine #(
  parameter int NUM_EP = 3,
  parameter int EP_SIZE = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [usb_ep_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tok_valid,
  input wire logic [1:0] tok_pid,
  input wire logic [usb_ep_pkg::EP_W-1:0] tok_ep,
  input wire logic tok_addr_ok,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  input wire logic rx_toggle,
  input wire logic host_ack,
  input wire logic host_timeout,
  output logic hs_valid,
  output logic [1:0] hs_code,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_zero,
  output logic tx_toggle,
  output logic [NUM_EP-1:0] ep_event
);
  import usb_ep_pkg::*;

  localparam int BUF_N = NUM_EP * EP_SIZE;
  localparam int BI_W = $clog2(BUF_N);
  localparam logic [CNT_W-1:0] MAX_RX = CNT_W'(EP_SIZE + CRC_BYTES);

  logic [7:0] mode_r [NUM_EP];
  logic [7:0] cnt_r [NUM_EP];
  logic [7:0] buf_r [BUF_N];
  state_t st_r;
  logic [EP_W-1:0] ep_r;
  logic setup_r, act_r, store_r, lock_r, tz_r;
  logic [CNT_W-1:0] rxn_r;
  logic [3:0] txn_r, txlen_r;
  logic pend_mchg_r;
  logic [3:0] pend_mode_r;

  // Flat buffer index of one byte of one endpoint; shared by USB and CPU paths.
  function automatic logic [BI_W-1:0] buf_index(input logic [EP_W-1:0] ep,
                                                input logic [3:0] idx);
    buf_index = BI_W'(int'(ep) * EP_SIZE + int'(idx));
  endfunction

  // Applies token status flags and a mode change; only endpoint 0 keeps in/out flags.
  function automatic logic [7:0] mode_apply(input logic [7:0] m, input logic ctl,
                                            input logic si, input logic so,
                                            input logic sa, input logic mc,
                                            input logic [3:0] nm);
    logic [7:0] r;
    r = m;
    if (ctl && si) r[MB_IN] = 1'b1;
    if (ctl && so) r[MB_OUT] = 1'b1;
    if (sa) r[MB_ACK] = 1'b1;
    if (mc) r[3:0] = nm;
    mode_apply = r;
  endfunction

  // Token qualification: bad address or nonexistent endpoint draws no response at all.
  logic tok_ok;
  logic [EP_W-1:0] tsel;
  logic [3:0] tmode;
  logic tstall;
  assign tok_ok = tok_valid && tok_addr_ok && (int'(tok_ep) < NUM_EP) && (st_r == ST_IDLE);
  assign tsel = tok_ok ? tok_ep : '0;
  assign tmode = mode_r[tsel][3:0];
  assign tstall = (tsel != '0) && mode_r[tsel][MB_STALL];

  // Modes that answer a SETUP token.
  logic setup_acc;
  always_comb begin
    case (tmode)
      M_NAK_IO, M_ST_OUT_ONLY, M_STALL_IO, M_IGNORE_IO, M_ST_IN_ONLY,
      M_NAK_OUT_ST_IN, M_ACK_OUT_ST_IN, M_NAK_IN_ST_OUT, M_ACK_IN_ST_OUT: setup_acc = 1'b1;
      default: setup_acc = 1'b0;
    endcase
  end

  // Transaction decisions. Everything that changes endpoint state goes through e_*, except the setup flag (setup_set).
  logic e_mwe, e_cwe, e_int, e_send, e_acked;
  logic [EP_W-1:0] e_ep;
  logic [7:0] e_mval, e_cval;
  logic [1:0] e_code;
  logic i_tx, i_zero, i_mchg;
  logic [3:0] i_mode;
  logic valid_rx;
  logic [3:0] cm;
  logic si, so, sa, mc, dv, upd;
  logic [3:0] nm;
  assign valid_rx = rx_crc_ok && (rxn_r <= MAX_RX);
  assign cm = mode_r[ep_r][3:0];

  always_comb begin
    e_ep = ep_r;
    e_mwe = 1'b0;
    e_cwe = 1'b0;
    e_int = 1'b0;
    e_send = 1'b0;
    e_code = HS_ACK;
    e_acked = 1'b0;
    i_tx = 1'b0;
    i_zero = 1'b0;
    i_mchg = 1'b0;
    i_mode = tmode;
    si = 1'b0;
    so = 1'b0;
    sa = 1'b0;
    mc = 1'b0;
    nm = cm;
    dv = 1'b0;
    upd = 1'b0;
    case (st_r)
      ST_IDLE: begin
        e_ep = tsel;
        nm = tmode;
        if (tok_ok && tok_pid == PID_IN) begin
          case (tmode)
            M_NAK_IO, M_NAK_IN_ST_OUT: begin
              e_send = 1'b1;
              e_code = HS_NAK;
              si = 1'b1;
            end
            M_STALL_IO: begin
              e_send = 1'b1;
              e_code = HS_STALL;
              si = 1'b1;
            end
            M_ST_OUT_ONLY: begin
              e_send = 1'b1;
              e_code = HS_STALL;
              si = 1'b1;
              mc = 1'b1;
              nm = M_STALL_IO;
            end
            M_ACK_OUT_ST_IN, M_NAK_OUT_ST_IN, M_ST_IN_ONLY: begin
              i_tx = 1'b1;
              i_zero = 1'b1;
            end
            M_ACK_IN_ST_OUT: begin
              i_tx = 1'b1;
              i_mchg = 1'b1;
              i_mode = M_NAK_IN_ST_OUT;
            end
            M_ACK_IN: begin
              if (tstall) begin
                e_send = 1'b1;
                e_code = HS_STALL;
                si = 1'b1;
                sa = 1'b1;
                mc = 1'b1;
                nm = M_NAK_IN;
              end else begin
                i_tx = 1'b1;
                i_mchg = 1'b1;
                i_mode = M_NAK_IN;
              end
            end
            M_ACK_OUT: begin
              e_send = tstall;
              e_code = HS_STALL;
            end
            default: ;
          endcase
          e_mwe = e_send;
          e_int = e_send && !(tmode == M_ACK_OUT);
        end
      end
      ST_RX: begin
        if (rx_end && act_r) begin
          if (setup_r) begin
            upd = 1'b1;
            dv = rx_crc_ok;
            e_int = 1'b1;
            if (valid_rx) begin
              e_send = 1'b1;
              sa = 1'b1;
              mc = 1'b1;
              nm = M_NAK_IO;
            end
          end else begin
            case (cm)
              M_NAK_IO: begin
                e_send = valid_rx;
                e_code = HS_NAK;
                so = valid_rx;
              end
              M_STALL_IO: begin
                e_send = valid_rx;
                e_code = HS_STALL;
                so = valid_rx;
              end
              M_ACK_OUT_ST_IN, M_ACK_OUT: begin
                upd = 1'b1;
                dv = rx_crc_ok;
                e_int = 1'b1;
                so = (cm == M_ACK_OUT_ST_IN);
                if (valid_rx) begin
                  e_send = 1'b1;
                  sa = 1'b1;
                  mc = 1'b1;
                  nm = (cm == M_ACK_OUT) ? M_NAK_OUT : M_NAK_OUT_ST_IN;
                end
              end
              M_NAK_OUT_ST_IN, M_NAK_OUT: begin
                e_send = valid_rx;
                e_code = HS_NAK;
                so = valid_rx;
              end
              M_ST_IN_ONLY: begin
                e_send = valid_rx;
                e_code = HS_STALL;
                so = valid_rx;
                mc = valid_rx;
                nm = M_STALL_IO;
              end
              M_ACK_IN_ST_OUT, M_NAK_IN_ST_OUT, M_ST_OUT_ONLY: begin
                if (valid_rx) begin
                  e_send = 1'b1;
                  upd = 1'b1;
                  dv = 1'b1;
                  so = 1'b1;
                  if (rxn_r == ZLP_CNT && rx_toggle) begin
                    sa = 1'b1;
                  end else begin
                    e_code = HS_STALL;
                    mc = 1'b1;
                    nm = M_STALL_IO;
                  end
                end
              end
              M_ISO_OUT: begin
                upd = 1'b1;
                dv = valid_rx;
                so = 1'b1;
                sa = 1'b1;
                e_int = 1'b1;
              end
              default: ;
            endcase
            e_int = e_int || e_send;
          end
          e_acked = e_send && (e_code == HS_ACK);
          e_mwe = e_send || e_int;
          e_cwe = upd;
        end
      end
      ST_WAIT: begin
        if (host_ack) begin
          si = 1'b1;
          sa = 1'b1;
          mc = pend_mchg_r;
          nm = pend_mode_r;
          e_mwe = 1'b1;
          e_int = 1'b1;
          e_acked = 1'b1;
        end
      end
      default: ;
    endcase
    e_mval = mode_apply(mode_r[e_ep], e_ep == '0, si, so, sa, mc, nm);
    e_cval = {rx_toggle, dv, rxn_r};
  end

  // Wishbone decode; answers in the cycle after the request is seen.
  logic wb_hit, a_is_buf, a_reg_ok, a_buf_ok, cpu_mwe, cpu_cwe, cpu_bwe, rd_ep0;
  logic [EP_W-1:0] a_ep, b_ep;
  logic [1:0] a_kind;
  logic [BUF_IDX_W-1:0] b_idx;
  logic [ADR_W-1:0] b_off;
  logic [BI_W-1:0] b_at;
  logic [7:0] rd_val;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign a_is_buf = (wb_adr_i >= BUF_BASE);
  assign a_ep = wb_adr_i[REG_EP_LSB +: EP_W];
  assign a_kind = wb_adr_i[REG_KIND_LSB +: 2];
  assign b_off = wb_adr_i - BUF_BASE;
  assign b_ep = b_off[BUF_EP_LSB +: EP_W];
  assign b_idx = b_off[BUF_IDX_LSB +: BUF_IDX_W];
  assign a_reg_ok = !a_is_buf && (int'(a_ep) < NUM_EP) && (wb_adr_i[1:0] == 2'h0)
                    && (wb_adr_i[7:REG_EP_LSB+EP_W] == '0)
                    && (a_kind == KIND_MODE || a_kind == KIND_CNT);
  assign a_buf_ok = a_is_buf && (int'(b_ep) < NUM_EP) && (int'(b_idx) < EP_SIZE)
                    && (b_off[7:BUF_EP_LSB+EP_W] == '0) && (b_off[1:0] == 2'h0);
  assign b_at = a_buf_ok ? buf_index(b_ep, 4'(b_idx)) : '0;
  assign cpu_mwe = wb_hit && wb_we_i && wb_sel_i[0] && a_reg_ok && a_kind == KIND_MODE
                   && !(a_ep == '0 && lock_r);
  assign cpu_cwe = wb_hit && wb_we_i && wb_sel_i[0] && a_reg_ok && a_kind == KIND_CNT
                   && !(a_ep == '0 && lock_r);
  assign cpu_bwe = wb_hit && wb_we_i && wb_sel_i[0] && a_buf_ok;
  assign rd_ep0 = wb_hit && !wb_we_i && a_reg_ok && a_ep == '0;

  // Read data mux; bits above the low byte and unmapped addresses read zero.
  always_comb begin
    rd_val = 8'h00;
    if (a_reg_ok && a_kind == KIND_MODE) begin
      rd_val = (a_ep == '0) ? mode_r[a_ep] : (mode_r[a_ep] & NONCTL_MASK);
    end else if (a_reg_ok) begin
      rd_val = cnt_r[a_ep];
    end else if (a_buf_ok) begin
      rd_val = buf_r[b_at];
    end
  end

  // Bus answer. Unmapped accesses are acknowledged and do nothing.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) wb_dat_o <= {24'h00_0000, rd_val};
    end
  end

  // Setup flag rises at the first data byte of an accepted SETUP and is never locked.
  logic setup_set;
  assign setup_set = (st_r == ST_RX) && act_r && setup_r && ep_r == '0
                     && rx_byte_valid && rxn_r == '0;

  // Mode registers. Engine updates win over a CPU write in the same cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_EP; i++) mode_r[i] <= MODE_RST;
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (e_mwe && int'(e_ep) == i) begin
          mode_r[i] <= e_mval;
        end else if (cpu_mwe && int'(a_ep) == i) begin
          mode_r[i] <= (i == 0) ? wb_dat_i[7:0] : (wb_dat_i[7:0] & NONCTL_MASK);
        end
      end
      if (setup_set) mode_r[0][MB_SETUP] <= 1'b1;
    end
  end

  // Count registers: toggle, data-valid and received byte count including CRC.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_EP; i++) cnt_r[i] <= CNT_RST;
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (e_cwe && int'(e_ep) == i) begin
          cnt_r[i] <= e_cval;
        end else if (cpu_cwe && int'(a_ep) == i) begin
          cnt_r[i] <= wb_dat_i[7:0];
        end
      end
    end
  end

  // Endpoint 0 interlock; a lock set in the same cycle as a read stays set.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_r <= 1'b0;
    end else if (e_acked && e_ep == '0) begin
      lock_r <= 1'b1;
    end else if (rd_ep0) begin
      lock_r <= 1'b0;
    end
  end

  // Buffer storage. Bytes past the endpoint size are counted but not stored.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < BUF_N; i++) buf_r[i] <= 8'h00;
    end else begin
      if (st_r == ST_RX && store_r && rx_byte_valid && int'(rxn_r) < EP_SIZE) begin
        buf_r[buf_index(ep_r, rxn_r[3:0])] <= rx_byte;
      end else if (cpu_bwe) begin
        buf_r[b_at] <= wb_dat_i[7:0];
      end
    end
  end

  // Transaction sequencer.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      ep_r <= '0;
      setup_r <= 1'b0;
      act_r <= 1'b0;
      store_r <= 1'b0;
      rxn_r <= '0;
      tz_r <= 1'b0;
      txlen_r <= 4'h0;
      pend_mchg_r <= 1'b0;
      pend_mode_r <= M_DISABLED;
    end else begin
      case (st_r)
        ST_IDLE: begin
          rxn_r <= '0;
          if (tok_ok) begin
            ep_r <= tok_ep;
            if (tok_pid == PID_IN) begin
              if (i_tx) begin
                st_r <= ST_TX;
                pend_mchg_r <= i_mchg;
                pend_mode_r <= i_mode;
                txlen_r <= (int'(cnt_r[tsel][3:0]) > EP_SIZE) ? 4'(EP_SIZE) : cnt_r[tsel][3:0];
                tz_r <= i_zero || cnt_r[tsel][3:0] == 4'h0;
              end
            end else if (tok_pid == PID_SETUP || tok_pid == PID_OUT) begin
              st_r <= ST_RX;
              setup_r <= (tok_pid == PID_SETUP);
              act_r <= (tok_pid == PID_OUT) || setup_acc;
              store_r <= (tok_pid == PID_SETUP) ? setup_acc :
                         (tmode == M_ACK_OUT_ST_IN || tmode == M_ACK_OUT || tmode == M_ISO_OUT);
            end
          end
        end
        ST_RX: begin
          if (rx_byte_valid && rxn_r != '1) rxn_r <= rxn_r + 1'b1;
          if (rx_end) st_r <= ST_IDLE;
        end
        ST_TX: begin
          if (tz_r || (tx_valid && tx_ready && tx_last)) st_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (host_ack || host_timeout) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Transmit stream from the endpoint buffer, paced by tx_ready.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      tx_zero <= 1'b0;
      tx_toggle <= 1'b0;
      txn_r <= 4'h0;
    end else begin
      tx_zero <= (st_r == ST_TX) && tz_r;
      if (st_r == ST_IDLE) begin
        txn_r <= 4'h0;
        tx_toggle <= cnt_r[tsel][CB_TOG];
      end
      if (tx_valid && tx_ready && tx_last) begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
      end else if (st_r == ST_TX && !tz_r && (!tx_valid || tx_ready) && txn_r < txlen_r) begin
        tx_valid <= 1'b1;
        tx_data <= buf_r[buf_index(ep_r, txn_r)];
        tx_last <= (txn_r == txlen_r - 4'h1);
        txn_r <= txn_r + 4'h1;
      end
    end
  end

  // Handshake and endpoint event pulses, one cycle each.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hs_valid <= 1'b0;
      hs_code <= HS_ACK;
      ep_event <= '0;
    end else begin
      hs_valid <= e_send;
      if (e_send) hs_code <= e_code;
      for (int i = 0; i < NUM_EP; i++) ep_event[i] <= e_int && int'(e_ep) == i;
    end
  end
endmodule
`default_nettype wire

// ==== usb_ep_pkg.sv ====
`default_nettype none
package usb_ep_pkg;
  // Register map on the Wishbone slave, byte addresses.
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_MODE_OFS = 8'h00;
  localparam logic [7:0] REG_CNT_OFS = 8'h04;
  localparam logic [7:0] BUF_BASE = 8'h40;
  localparam int REG_EP_LSB = 4;
  localparam int REG_KIND_LSB = 2;
  localparam int BUF_EP_LSB = 5;
  localparam int BUF_IDX_LSB = 2;
  localparam int BUF_IDX_W = 3;
  localparam logic [1:0] KIND_MODE = 2'h0;
  localparam logic [1:0] KIND_CNT = 2'h1;

  // Endpoint addressing and packet framing.
  localparam int EP_W = 2;
  localparam int CRC_BYTES = 2;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] ZLP_CNT = 6'h02;

  // Mode register fields.
  localparam int MB_STALL = 7;
  localparam int MB_SETUP = 7;
  localparam int MB_IN = 6;
  localparam int MB_OUT = 5;
  localparam int MB_ACK = 4;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] NONCTL_MASK = 8'h9f;

  // Count register fields.
  localparam int CB_TOG = 7;
  localparam int CB_DVAL = 6;
  localparam logic [7:0] CNT_RST = 8'h00;

  // Endpoint modes.
  localparam logic [3:0] M_DISABLED = 4'h0;
  localparam logic [3:0] M_NAK_IO = 4'h1;
  localparam logic [3:0] M_ST_OUT_ONLY = 4'h2;
  localparam logic [3:0] M_STALL_IO = 4'h3;
  localparam logic [3:0] M_IGNORE_IO = 4'h4;
  localparam logic [3:0] M_ISO_OUT = 4'h5;
  localparam logic [3:0] M_ST_IN_ONLY = 4'h6;
  localparam logic [3:0] M_NAK_OUT = 4'h8;
  localparam logic [3:0] M_ACK_OUT = 4'h9;
  localparam logic [3:0] M_NAK_OUT_ST_IN = 4'ha;
  localparam logic [3:0] M_ACK_OUT_ST_IN = 4'hb;
  localparam logic [3:0] M_NAK_IN = 4'hc;
  localparam logic [3:0] M_ACK_IN = 4'hd;
  localparam logic [3:0] M_NAK_IN_ST_OUT = 4'he;
  localparam logic [3:0] M_ACK_IN_ST_OUT = 4'hf;

  // Token kinds from the serial_interface_engine and handshake codes to it.
  localparam logic [1:0] PID_OUT = 2'h0;
  localparam logic [1:0] PID_IN = 2'h1;
  localparam logic [1:0] PID_SETUP = 2'h2;
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_WAIT} state_t;
endpackage
`default_nettype wire

// ==== usb_endpoint_response_engine_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_response_engine_properties #(
  parameter int NUM_EP = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tok_valid,
  input wire logic tok_addr_ok,
  input wire logic rx_end,
  input wire logic hs_valid,
  input wire logic [1:0] hs_code,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_zero,
  input wire logic [NUM_EP-1:0] ep_event
);
  import usb_ep_pkg::*;
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_WB_ACK: assert property (s_req |=> s_ack_pulse)
    else $error("bus access not answered by a single ack");
  AST_HS_EVT: assert property (hs_valid && hs_code != HS_STALL |-> ep_event != '0)
    else $error("ack or nak sent without endpoint event");
  AST_EVT_ONE: assert property ($onehot0(ep_event))
    else $error("more than one endpoint event at once");
  AST_BAD_ADDR: assert property (tok_valid && !tok_addr_ok && !rx_end
    |=> !hs_valid && !tx_zero)
    else $error("answer given to a foreign token");
  AST_ZLP_EXCL: assert property (tx_zero |-> !tx_valid && !hs_valid)
    else $error("zero length packet mixed with other answer");
  AST_ZLP_PULSE: assert property (tx_zero |=> !tx_zero)
    else $error("zero length request longer than one cycle");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("data byte dropped or changed while stalled");
  AST_RST_QUIET: assert property ($fell(rst) |-> !hs_valid && ep_event == '0 && !tx_valid)
    else $error("activity right after reset");
endmodule
bind usb_endpoint_response_engine usb_endpoint_response_engine_properties #(.NUM_EP(NUM_EP))
  u_prop (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .tok_valid(tok_valid), .tok_addr_ok(tok_addr_ok), .rx_end(rx_end), .hs_valid(hs_valid),
  .hs_code(hs_code), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .tx_zero(tx_zero), .ep_event(ep_event));
`default_nettype wire

// ==== usb_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
  input wire logic clk_sys,
  output logic tok_valid,
  output logic [1:0] tok_pid,
  output logic [1:0] tok_ep,
  output logic tok_addr_ok,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_end,
  output logic rx_crc_ok,
  output logic rx_toggle,
  output logic host_ack,
  output logic host_timeout,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_zero
);
  // Quiet bus at time zero; the host never times out in these runs.
  initial begin
    {tok_valid, tok_pid, tok_ep, tok_addr_ok, rx_byte_valid, rx_end} = '0;
    {rx_byte, rx_crc_ok, rx_toggle, host_ack, host_timeout, tx_ready} = '0;
  end
  // The host stalls at random and acknowledges the last byte or an empty packet.
  always @(posedge clk_sys) begin
    tx_ready <= 1'($urandom);
    host_ack <= (tx_valid && tx_ready && tx_last) || tx_zero;
  end
  task automatic tok(input logic [1:0] pid, input logic [1:0] ep, input logic ok);
    @(posedge clk_sys);
    {tok_valid, tok_pid, tok_ep, tok_addr_ok} <= {1'b1, pid, ep, ok};
    @(posedge clk_sys);
    tok_valid <= 1'b0;
  endtask
  // Bytes count the two check bytes; the idle byte lane flips so it never looks stable.
  task automatic data(input int n, input logic crc);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'($urandom);
    end
    @(posedge clk_sys);
    {rx_byte_valid, rx_end, rx_crc_ok, rx_toggle} <= {1'b0, 1'b1, crc, 1'b0};
    rx_byte <= ~rx_byte;
    @(posedge clk_sys);
    rx_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== usb_endpoint_response_engine_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_response_engine_tb;
  import usb_ep_pkg::*;
  logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hs_valid, tx_ready, tx_valid;
  logic tx_last, tx_zero, tx_toggle, tok_valid, tok_addr_ok, rx_byte_valid, rx_end;
  logic rx_crc_ok, rx_toggle, host_ack, host_timeout;
  logic [1:0] tok_pid, tok_ep, hs_code;
  logic [3:0] wb_sel_i;
  logic [7:0] wb_adr_i, rx_byte, tx_data;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [2:0] ep_event;
  logic [31:0] hs_q[$], rd_q[$];
  int num_errors = 0;
  int n_tests = 0;
  int n_evt = 0;
  usb_endpoint_response_engine #(.NUM_EP(3), .EP_SIZE(8)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_ep(tok_ep),
    .tok_addr_ok(tok_addr_ok), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .rx_toggle(rx_toggle), .host_ack(host_ack),
    .host_timeout(host_timeout), .hs_valid(hs_valid), .hs_code(hs_code), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_zero(tx_zero),
    .tx_toggle(tx_toggle), .ep_event(ep_event));
  usb_host_model u_host (
    .clk_sys(clk_sys), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_ep(tok_ep),
    .tok_addr_ok(tok_addr_ok), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .rx_toggle(rx_toggle), .host_ack(host_ack),
    .host_timeout(host_timeout), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_zero(tx_zero));
  // Free running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Classic single cycle; the request is held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 24'h0, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back({24'h0, exp});
    wb(1'b0, a, 8'h00);
  endtask
  // Expected answer 4 means an empty data packet, 15 means silence.
  task automatic xact(input logic [1:0] pid, input logic [1:0] ep, input logic ok, input int n,
                      input logic crc, input logic [31:0] exp);
    if (exp !== 32'hf) hs_q.push_back(exp);
    u_host.tok(pid, ep, ok);
    if (pid != PID_IN) u_host.data(n, crc);
    repeat (30) @(posedge clk_sys);
  endtask
  // Each result is matched against the oldest note.
  always @(posedge clk_sys) begin
    if (hs_valid === 1'b1) chk({30'h0, hs_code}, hs_q.size() ? hs_q.pop_front() : 32'hx);
    if (tx_zero === 1'b1) chk(32'h4, hs_q.size() ? hs_q.pop_front() : 32'hx);
    if ((tx_valid & tx_ready) === 1'b1)
      chk({tx_toggle, tx_last, tx_data}, hs_q.size() ? hs_q.pop_front() : 32'hx);
    if (ep_event !== 3'h0) n_evt++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk(wb_dat_o, rd_q.size() ? rd_q.pop_front() : 32'hx);
  end
  // A hang is cut short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hca76));
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 43'h0};
    wb_sel_i = 4'h1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h10, 8'h00);
    rd(8'h24, 8'h00);
    wb(1'b1, 8'h00, 8'h0a);
    xact(PID_IN, 2'h0, 1'b1, 0, 1'b1, 32'h4);
    rd(8'h00, 8'h5a);
    xact(PID_IN, 2'h0, 1'b0, 0, 1'b1, 32'hf);
    wb(1'b1, 8'h00, 8'h01);
    xact(PID_IN, 2'h0, 1'b1, 0, 1'b1, {30'h0, HS_NAK});
    xact(PID_SETUP, 2'h0, 1'b1, 10, 1'b1, {30'h0, HS_ACK});
    wb(1'b1, 8'h00, 8'h03);
    rd(8'h04, 8'h4a);
    rd(8'h00, 8'hd1);
    wb(1'b1, 8'h00, 8'h03);
    xact(PID_OUT, 2'h0, 1'b1, 2, 1'b1, {30'h0, HS_STALL});
    wb(1'b1, 8'h10, 8'h09);
    xact(PID_OUT, 2'h1, 1'b1, 6, 1'b1, {30'h0, HS_ACK});
    rd(8'h10, 8'h18);
    xact(PID_OUT, 2'h1, 1'b1, 6, 1'b0, 32'hf);
    xact(PID_OUT, 2'h1, 1'b1, 6, 1'b1, {30'h0, HS_NAK});
    wb(1'b1, 8'h14, 8'h82);
    wb(1'b1, 8'h60, 8'h3c);
    wb(1'b1, 8'h64, 8'hc3);
    wb(1'b1, 8'h10, 8'h0f);
    hs_q.push_back(32'h23c);
    hs_q.push_back(32'h3c3);
    xact(PID_IN, 2'h1, 1'b1, 0, 1'b1, 32'hf);
    rd(8'h10, 8'h1e);
    xact(PID_OUT, 2'h2, 1'b1, 4, 1'b1, 32'hf);
    wb(1'b1, 8'h20, 8'h8d);
    xact(PID_IN, 2'h2, 1'b1, 0, 1'b1, {30'h0, HS_STALL});
    rd(8'hf0, 8'h00);
    chk(n_evt, 8);
    chk(hs_q.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire
